// ===== bench/cdio_asserts.sv
`timescale 1ns/1ps
module cdio_asserts (
  // Clock and reset
  input wire logic                     clk,
  input wire logic                     nrst,
  // Watched pins
  input wire logic [cdio_pkg::NIN-1:0] field_in,
  input wire logic                     comp_start_o,
  input wire logic                     remote_en_o,
  input wire logic                     shunt_trip_o,
  input wire logic                     trip_ok_o,
  input wire logic [7:0]               slide_cmd_o
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // Six cycles cover two synchroniser flops plus the output register
  hl_stop_a: assert property (!field_in[cdio_pkg::IN_HL] [*6] |-> !comp_start_o)
    else $error("start held with level switch open");
  oil1_stop_a: assert property (!field_in[cdio_pkg::IN_OIL1] [*6] |-> !comp_start_o)
    else $error("start held with float one open");
  oil2_stop_a: assert property (!field_in[cdio_pkg::IN_OIL2] [*6] |-> !comp_start_o)
    else $error("start held with float two open");
  trip_ind_a: assert property (!field_in[cdio_pkg::IN_HL] [*6] |-> !trip_ok_o)
    else $error("trip indicator on during trip");
  remote_trip_a: assert property (!trip_ok_o [*2] |-> !remote_en_o)
    else $error("remote enabled during trip");
  shunt_cmd_a: assert property (shunt_trip_o |-> !comp_start_o)
    else $error("shunt trip while commanded to run");
  idle_slide_a: assert property (!comp_start_o [*3] |=> $stable(slide_cmd_o))
    else $error("slide moved while stopped");
  reset_out_a: assert property ($rose(nrst) |-> !comp_start_o && !shunt_trip_o)
    else $error("output active at reset release");
endmodule : cdio_asserts
bind cdio_top cdio_asserts u_asserts (.clk(clk), .nrst(nrst), .field_in(field_in),
  .comp_start_o(comp_start_o), .remote_en_o(remote_en_o), .shunt_trip_o(shunt_trip_o),
  .trip_ok_o(trip_ok_o), .slide_cmd_o(slide_cmd_o));

// ===== bench/cdio_field.sv
`timescale 1ns/1ps
module cdio_field (
  // Clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // Switch levels and starter drive
  input wire logic [7:0] sw,
  input wire logic       run_cmd,
  input wire logic       stray_run,
  // Field pins
  output logic     [15:0] pins
);
  logic [2:0] fb_r;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) fb_r <= 3'h0;
    else fb_r <= {fb_r[1:0], run_cmd | stray_run};
  assign pins = {8'h00, sw[7:1], fb_r[2]};
endmodule : cdio_field

// ===== bench/cdio_top_tb.sv
`timescale 1ns/1ps
module cdio_top_tb;
  localparam int SC = 20;
  logic clk = 0, nrst = 0, wr = 0, rd = 0, stray = 0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wd = 16'h0000, rdat, sp, pins;
  logic [15:0] lp = 16'h0000;
  logic [7:0] sw = 8'h0E, slide, s0, spd;
  logic [7:0] spct = 8'h00;
  logic start, ren, shunt, tok, aok, inj2;
  int errors = 0, checked = 0;
  initial forever #2.5 clk = ~clk;
  cdio_field u_fld (.clk(clk), .nrst(nrst), .sw(sw), .run_cmd(start), .stray_run(stray),
    .pins(pins));
  cdio_top #(.SCAN_CYC(SC)) dut (.clk(clk), .nrst(nrst), .reg_addr(addr), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .field_in(pins), .liq_press(lp),
    .slide_pct(spct), .comp_start_o(start), .remote_en_o(ren), .shunt_trip_o(shunt),
    .liq_inj2_o(inj2), .trip_ok_o(tok), .alarm_ok_o(aok), .slide_cmd_o(slide),
    .speed_cmd_o(spd), .ctrl_sp_o(sp), .sp2_sel_o());
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rchk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdat, e);
  endtask : rchk
  task automatic scans(input int n);
    repeat (n * SC) @(posedge clk);
  endtask : scans
  task automatic finish_test();
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    #200_000;
    errors++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    chk({15'h0000, start}, 16'h0000);
    wreg(4'hF, 16'hFFFF);
    rchk(cdio_pkg::R_CTRL, cdio_pkg::CTRL_RST);
    rchk(cdio_pkg::R_ARC, cdio_pkg::ARC_RST);
    wreg(cdio_pkg::R_CTRL, 16'h0001);
    scans(10);
    chk({15'h0000, ren}, 16'h0001);
    sw[5] <= 1'b1;
    for (int i = 0; i < 3000 && start !== 1'b1; i++) @(posedge clk);
    chk({14'h0000, start, tok}, 16'h0003);
    chk({15'h0000, aok}, 16'h0001);
    s0 = slide;
    sw[6] <= 1'b1;
    scans(3);
    sw[6] <= 1'b0;
    repeat (5) @(posedge clk);
    chk({15'h0000, slide > s0}, 16'h0001);
    s0 = slide;
    scans(2);
    chk({8'h00, slide}, {8'h00, s0});
    sw[7] <= 1'b1;
    scans(2);
    sw[7] <= 1'b0;
    chk({15'h0000, slide < s0}, 16'h0001);
    wreg(cdio_pkg::R_CTRL, 16'h0009);
    sw[6] <= 1'b1;
    scans(3);
    sw[6] <= 1'b0;
    repeat (5) @(posedge clk);
    chk({15'h0000, spd > 8'h00}, 16'h0001);
    wreg(cdio_pkg::R_LIQTHR, 16'h0100);
    wreg(cdio_pkg::R_SLDTHR, 16'h0032);
    lp <= 16'h0200;
    spct <= 8'h40;
    wreg(cdio_pkg::R_CTRL, 16'h0005);
    repeat (3) @(posedge clk);
    chk({15'h0000, inj2}, 16'h0001);
    spct <= 8'h10;
    repeat (3) @(posedge clk);
    chk({15'h0000, inj2}, 16'h0000);
    wreg(cdio_pkg::R_SP1, 16'h0123);
    wreg(cdio_pkg::R_SP2, 16'h0456);
    wreg(cdio_pkg::R_CTRL, 16'h0023);
    scans(1);
    chk(sp, 16'h0123);
    sw[4] <= 1'b1;
    scans(1);
    chk(sp, 16'h0456);
    sw[3:1] <= 3'h0;
    repeat (10) @(posedge clk);
    chk({13'h0000, start, tok, ren}, 16'h0000);
    sw[3:1] <= 3'h7;
    scans(1);
    chk({15'h0000, tok}, 16'h0000);
    sw[5] <= 1'b0;
    wreg(cdio_pkg::R_TRIP, 16'hFFFF);
    repeat (3) @(posedge clk);
    chk({15'h0000, tok}, 16'h0001);
    wreg(cdio_pkg::R_CTRL, 16'h0011);
    stray <= 1'b1;
    scans(4);
    chk({15'h0000, shunt}, 16'h0001);
    rchk(cdio_pkg::R_TRIP, 16'h0008);
    finish_test();
  end
endmodule : cdio_top_tb

// ===== rtl/cdio_io_if.sv
`timescale 1ns/1ps
interface cdio_io_if;
  logic [cdio_pkg::NIN-1:0] pins_s;
  logic                     tick;
  modport src (output pins_s, output tick);
  modport dst (input pins_s, input tick);
endinterface : cdio_io_if

// ===== rtl/cdio_pkg.sv
package cdio_pkg;
  // Clock and scan timing
  localparam int CLK_NS   = 5;
  localparam int SCAN_MS  = 1000;
  localparam int SCAN_CYC = SCAN_MS * 1_000_000 / CLK_NS;
  localparam int CNT_W    = 28;
  // Bus and vector widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int NIN    = 16;
  localparam int NAUX   = 8;
  localparam int NTRIP  = 12;
  localparam int NALM   = 9;
  // Raw input positions
  localparam int IN_FB    = 0;
  localparam int IN_HL    = 1;
  localparam int IN_OIL1  = 2;
  localparam int IN_OIL2  = 3;
  localparam int IN_SPSEL = 4;
  localparam int IN_START = 5;
  localparam int IN_RAISE = 6;
  localparam int IN_LOWER = 7;
  localparam int IN_AUX0  = 8;
  // Register indices
  localparam logic [ADDR_W-1:0] R_CTRL    = 4'h0;
  localparam logic [ADDR_W-1:0] R_AUXCFG  = 4'h1;
  localparam logic [ADDR_W-1:0] R_LIQTHR  = 4'h2;
  localparam logic [ADDR_W-1:0] R_SLDTHR  = 4'h3;
  localparam logic [ADDR_W-1:0] R_SP1     = 4'h4;
  localparam logic [ADDR_W-1:0] R_SP2     = 4'h5;
  localparam logic [ADDR_W-1:0] R_ARC     = 4'h6;
  localparam logic [ADDR_W-1:0] R_STATUS  = 4'h7;
  localparam logic [ADDR_W-1:0] R_TRIP    = 4'h8;
  localparam logic [ADDR_W-1:0] R_ALARM   = 4'h9;
  localparam logic [ADDR_W-1:0] R_INPUTS  = 4'hA;
  localparam logic [ADDR_W-1:0] R_CAP     = 4'hB;
  // Control bits
  localparam int C_DIRECT = 0;
  localparam int C_SPIN   = 1;
  localparam int C_DUAL   = 2;
  localparam int C_VFD    = 3;
  localparam int C_SHUNT  = 4;
  localparam int C_NCTRL2 = 5;
  localparam int C_MSTOP  = 6;
  // Trip and alarm bits
  localparam int T_HL    = 0;
  localparam int T_OIL1  = 1;
  localparam int T_OIL2  = 2;
  localparam int T_RUN   = 3;
  localparam int T_AUX0  = 4;
  localparam int A_FAIL  = 8;
  // Reset values and limits
  localparam logic [DATA_W-1:0] CTRL_RST   = 16'h0000;
  localparam logic [DATA_W-1:0] AUXCFG_RST = 16'h0000;
  localparam logic [DATA_W-1:0] LIQTHR_RST = 16'hFFFF;
  localparam logic [7:0]        SLDTHR_RST = 8'h64;
  localparam logic [DATA_W-1:0] SP_RST     = 16'h0000;
  localparam logic [DATA_W-1:0] ARC_RST    = 16'h0005;
  localparam logic [3:0]        FB_GRACE   = 4'h2;
  localparam logic [7:0]        CAP_MAX    = 8'h64;
  localparam logic [1:0]        PRIME_CNT  = 2'h3;

  typedef enum {CDIO_IDLE, CDIO_RUN} cdio_state_t;
endpackage : cdio_pkg

// ===== rtl/cdio_sync.sv
`timescale 1ns/1ps
module cdio_sync #(
  parameter int unsigned SCAN_CYC = cdio_pkg::SCAN_CYC
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     nrst,
  // Field pins
  input  wire logic [cdio_pkg::NIN-1:0] pins,
  // Synchronised side
  cdio_io_if.src                        io
);
  logic [cdio_pkg::NIN-1:0]   meta_r;
  logic [cdio_pkg::NIN-1:0]   sync_r;
  logic [cdio_pkg::CNT_W-1:0] div_r;
  logic                       tick_r;
  wire                        div_end = div_r == cdio_pkg::CNT_W'(SCAN_CYC - 1);

  genvar g;
  generate
    for (g = 0; g < cdio_pkg::NIN; g++) begin : g_sync
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
        end else begin
          meta_r[g] <= pins[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      div_r  <= div_end ? '0 : div_r + 1'b1;
      tick_r <= div_end;
    end
  end

  assign io.pins_s = sync_r;
  assign io.tick   = tick_r;
endmodule : cdio_sync

// ===== rtl/cdio_top.sv
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
// Summary of operation
// - Dual injection option drives injection two from liquid pressure and slide percent
// - Remote-enabled output asserted when panel is set for direct discrete control
// - Remote-enabled drops on warning, trip, anti-recycle running or manual stop
// - Motor running while not commanded may fire shunt trip output
// - High-level input must be active; dropping stops compressor, raises trip
// - Both oil float inputs must be active; each drop raises its trip
// - Setpoint input selects setpoint one when inactive, two when active
// - Remote start input active starts when available; inactive stops compressor
// - Raise and lower inputs sampled once per one-second scan
// - Remote raise while running increases slide, or speed with drive enabled
// - Raise keeps stepping every scan while active until CAP_MAX (100), stops once inactive
// - Trip indicator active with no trip, inactive when trip exists
// - Trip indicator stays off until the latched trip is cleared
// - Remote lower while running decreases slide or speed every scan until it reaches zero
// - Each auxiliary input configurable to raise alarm or trip
module cdio_top #(
  parameter int unsigned SCAN_CYC = cdio_pkg::SCAN_CYC
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        nrst,
  // Register port
  input  wire logic [cdio_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [cdio_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [cdio_pkg::DATA_W-1:0] reg_rdata,
  // Field discrete inputs
  input  wire logic [cdio_pkg::NIN-1:0]    field_in,
  // Measured values, same clock
  input  wire logic [cdio_pkg::DATA_W-1:0] liq_press,
  input  wire logic [7:0]                  slide_pct,
  // Discrete outputs
  output logic                             comp_start_o,
  output logic                             remote_en_o,
  output logic                             shunt_trip_o,
  output logic                             liq_inj2_o,
  output logic                             trip_ok_o,
  output logic                             alarm_ok_o,
  // Capacity and setpoint
  output logic      [7:0]                  slide_cmd_o,
  output logic      [7:0]                  speed_cmd_o,
  output logic      [cdio_pkg::DATA_W-1:0] ctrl_sp_o,
  output logic                             sp2_sel_o
);
  cdio_io_if io ();

  cdio_sync #(
    .SCAN_CYC (SCAN_CYC)
  ) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .pins (field_in),
    .io   (io)
  );

  // Saturating one-step move used for both slide and speed
  function automatic logic [7:0] cap_step(input logic [7:0] v, input logic up,
                                          input logic dn);
    logic [7:0] r;
    r = v;
    if (up && !dn && v < cdio_pkg::CAP_MAX) begin
      r = v + 8'h01;
    end else if (dn && !up && v != 8'h00) begin
      r = v - 8'h01;
    end
    return r;
  endfunction : cap_step

  // Configuration registers
  logic [cdio_pkg::DATA_W-1:0] ctrl_r;
  logic [cdio_pkg::DATA_W-1:0] auxcfg_r;
  logic [cdio_pkg::DATA_W-1:0] liqthr_r;
  logic [7:0]                  sldthr_r;
  logic [cdio_pkg::DATA_W-1:0] sp1_r;
  logic [cdio_pkg::DATA_W-1:0] sp2_r;
  logic [cdio_pkg::DATA_W-1:0] arc_r;
  // Block state
  cdio_pkg::cdio_state_t       state_r;
  cdio_pkg::cdio_state_t       state_nxt;
  logic [1:0]                  prime_r;
  logic [3:0]                  grace_r;
  logic [cdio_pkg::DATA_W-1:0] arc_cnt_r;
  logic [cdio_pkg::NTRIP-1:0]  trip_r;
  logic [cdio_pkg::NTRIP-1:0]  trip_now;
  logic [cdio_pkg::NTRIP-1:0]  trip_nxt;
  logic [cdio_pkg::NALM-1:0]   alarm_r;
  logic [cdio_pkg::NALM-1:0]   alarm_now;
  logic [cdio_pkg::NALM-1:0]   alarm_nxt;
  logic [cdio_pkg::DATA_W-1:0] rd_mux;
  // One strobe decoder shared by every register target
  function automatic logic reg_hit(input logic [cdio_pkg::ADDR_W-1:0] a,
                                   input logic [cdio_pkg::ADDR_W-1:0] idx,
                                   input logic                        stb);
    return stb && (a == idx);
  endfunction : reg_hit
  // Synchronised field inputs
  wire                      fb_in    = io.pins_s[cdio_pkg::IN_FB];
  wire                      hl_in    = io.pins_s[cdio_pkg::IN_HL];
  wire                      oil1_in  = io.pins_s[cdio_pkg::IN_OIL1];
  wire                      oil2_in  = io.pins_s[cdio_pkg::IN_OIL2];
  wire                      spsel_in = io.pins_s[cdio_pkg::IN_SPSEL];
  wire                      start_in = io.pins_s[cdio_pkg::IN_START];
  wire                      raise_in = io.pins_s[cdio_pkg::IN_RAISE];
  wire                      lower_in = io.pins_s[cdio_pkg::IN_LOWER];
  wire [cdio_pkg::NAUX-1:0] aux_in   = io.pins_s[cdio_pkg::IN_AUX0 +: cdio_pkg::NAUX];
  // Register write and clear strobes
  wire                       wr_ctrl   = reg_hit(reg_addr, cdio_pkg::R_CTRL, reg_wr);
  wire                       wr_auxcfg = reg_hit(reg_addr, cdio_pkg::R_AUXCFG, reg_wr);
  wire                       wr_liqthr = reg_hit(reg_addr, cdio_pkg::R_LIQTHR, reg_wr);
  wire                       wr_sldthr = reg_hit(reg_addr, cdio_pkg::R_SLDTHR, reg_wr);
  wire                       wr_sp1    = reg_hit(reg_addr, cdio_pkg::R_SP1, reg_wr);
  wire                       wr_sp2    = reg_hit(reg_addr, cdio_pkg::R_SP2, reg_wr);
  wire                       wr_arc    = reg_hit(reg_addr, cdio_pkg::R_ARC, reg_wr);
  wire                       wr_trip   = reg_hit(reg_addr, cdio_pkg::R_TRIP, reg_wr);
  wire                       wr_alarm  = reg_hit(reg_addr, cdio_pkg::R_ALARM, reg_wr);
  wire [cdio_pkg::NTRIP-1:0] trip_clr  = wr_trip ? reg_wdata[cdio_pkg::NTRIP-1:0] : '0;
  wire [cdio_pkg::NALM-1:0]  alarm_clr = wr_alarm ? reg_wdata[cdio_pkg::NALM-1:0] : '0;
  // Control field decode
  wire direct_en = ctrl_r[cdio_pkg::C_DIRECT];
  wire spin_en   = ctrl_r[cdio_pkg::C_SPIN];
  wire dual_en   = ctrl_r[cdio_pkg::C_DUAL];
  wire vfd_en    = ctrl_r[cdio_pkg::C_VFD];
  wire shunt_en  = ctrl_r[cdio_pkg::C_SHUNT];
  wire nctrl2_en = ctrl_r[cdio_pkg::C_NCTRL2];
  wire mstop_en  = ctrl_r[cdio_pkg::C_MSTOP];

  wire is_run      = state_r == cdio_pkg::CDIO_RUN;
  wire primed      = prime_r == cdio_pkg::PRIME_CNT;
  wire arc_busy    = arc_cnt_r != '0;
  wire fb_mismatch = fb_in != is_run;
  wire grace_out   = grace_r == cdio_pkg::FB_GRACE;
  wire run_uncmd   = grace_out && fb_in && !is_run;
  wire start_fail  = grace_out && !fb_in && is_run;
  wire [cdio_pkg::NAUX-1:0] aux_trip = aux_in & auxcfg_r[cdio_pkg::NAUX-1:0];
  wire [cdio_pkg::NAUX-1:0] aux_alm  = aux_in & ~auxcfg_r[cdio_pkg::NAUX-1:0];

  always_comb begin
    trip_now  = '0;
    alarm_now = '0;
    if (primed) begin
      trip_now[cdio_pkg::T_HL]                     = !hl_in;
      trip_now[cdio_pkg::T_OIL1]                   = !oil1_in;
      trip_now[cdio_pkg::T_OIL2]                   = !oil2_in;
      trip_now[cdio_pkg::T_RUN]                    = run_uncmd;
      trip_now[cdio_pkg::T_AUX0 +: cdio_pkg::NAUX] = aux_trip;
      alarm_now[cdio_pkg::NAUX-1:0]                = aux_alm;
      alarm_now[cdio_pkg::A_FAIL]                  = start_fail;
    end
  end
  // latched until software clears
  // A clear meeting a live fault loses, so no fault slips through
  assign trip_nxt  = (trip_r & ~trip_clr) | trip_now;
  assign alarm_nxt = (alarm_r & ~alarm_clr) | alarm_now;
  wire trip_any    = |trip_nxt;
  wire alarm_any   = |alarm_nxt;
  wire avail    = primed && direct_en && !trip_any && !arc_busy && !mstop_en;
  wire run_drop = !start_in || !direct_en || trip_any || mstop_en;
  wire stop_evt = is_run && (state_nxt == cdio_pkg::CDIO_IDLE);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      cdio_pkg::CDIO_IDLE: begin
        if (avail && start_in) begin
          state_nxt = cdio_pkg::CDIO_RUN;
        end
      end
      cdio_pkg::CDIO_RUN: begin
        if (run_drop) begin
          state_nxt = cdio_pkg::CDIO_IDLE;
        end
      end
      default: begin
        state_nxt = cdio_pkg::CDIO_IDLE;
      end
    endcase
  end

  // dropped on fault, anti-recycle or manual stop
  wire       ren_nxt   = avail && !alarm_any && !stop_evt;
  wire       shunt_nxt = shunt_en && trip_nxt[cdio_pkg::T_RUN];
  wire       inj2_nxt  = dual_en && is_run && (liq_press >= liqthr_r) && (slide_pct >= sldthr_r);
  wire       sp2_nxt   = spin_en && nctrl2_en && spsel_in;
  // capacity moves only on the scan tick
  wire       cap_scan  = io.tick && is_run && direct_en;
  wire [7:0] slide_nxt = cap_step(slide_cmd_o, raise_in, lower_in);
  wire [7:0] speed_nxt = cap_step(speed_cmd_o, raise_in, lower_in);

  // Configuration register writes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r   <= cdio_pkg::CTRL_RST;
      auxcfg_r <= cdio_pkg::AUXCFG_RST;
      liqthr_r <= cdio_pkg::LIQTHR_RST;
      sldthr_r <= cdio_pkg::SLDTHR_RST;
      sp1_r    <= cdio_pkg::SP_RST;
      sp2_r    <= cdio_pkg::SP_RST;
      arc_r    <= cdio_pkg::ARC_RST;
    end else begin
      if (wr_ctrl) ctrl_r <= reg_wdata;
      if (wr_auxcfg) auxcfg_r <= reg_wdata;
      if (wr_liqthr) liqthr_r <= reg_wdata;
      if (wr_sldthr) sldthr_r <= reg_wdata[7:0];
      if (wr_sp1) sp1_r <= reg_wdata;
      if (wr_sp2) sp2_r <= reg_wdata;
      if (wr_arc) arc_r <= reg_wdata;
    end
  end

  // Grace in scans so starter contact travel is not a fault
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      grace_r <= 4'h0;
    end else if (!fb_mismatch) begin
      grace_r <= 4'h0;
    end else if (io.tick && !grace_out) begin
      grace_r <= grace_r + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      arc_cnt_r <= '0;
    end else if (stop_evt) begin
      arc_cnt_r <= arc_r;
    end else if (io.tick && arc_busy) begin
      arc_cnt_r <= arc_cnt_r - 16'h0001;
    end
  end

  // State, fault latches and priming
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= cdio_pkg::CDIO_IDLE;
      trip_r  <= '0;
      alarm_r <= '0;
      prime_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      trip_r  <= trip_nxt;
      alarm_r <= alarm_nxt;
      if (!primed) begin
        prime_r <= prime_r + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      comp_start_o <= 1'b0;
      remote_en_o  <= 1'b0;
      shunt_trip_o <= 1'b0;
      liq_inj2_o   <= 1'b0;
      trip_ok_o    <= 1'b0;
      alarm_ok_o   <= 1'b0;
      sp2_sel_o    <= 1'b0;
      ctrl_sp_o    <= '0;
    end else begin
      comp_start_o <= state_nxt == cdio_pkg::CDIO_RUN;
      remote_en_o  <= ren_nxt;
      shunt_trip_o <= shunt_nxt;
      liq_inj2_o   <= inj2_nxt;
      trip_ok_o    <= primed && !trip_any;
      alarm_ok_o   <= primed && !alarm_any;
      sp2_sel_o    <= sp2_nxt;
      ctrl_sp_o    <= sp2_nxt ? sp2_r : sp1_r;
    end
  end

  // keeps stepping each scan while held, until CAP_MAX going up or zero going down
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      slide_cmd_o <= 8'h00;
      speed_cmd_o <= 8'h00;
    end else if (cap_scan) begin
      if (vfd_en) begin
        speed_cmd_o <= speed_nxt;
      end else begin
        slide_cmd_o <= slide_nxt;
      end
    end
  end

  always_comb begin
    case (reg_addr)
      cdio_pkg::R_CTRL:   rd_mux = ctrl_r;
      cdio_pkg::R_AUXCFG: rd_mux = auxcfg_r;
      cdio_pkg::R_LIQTHR: rd_mux = liqthr_r;
      cdio_pkg::R_SLDTHR: rd_mux = {8'h00, sldthr_r};
      cdio_pkg::R_SP1:    rd_mux = sp1_r;
      cdio_pkg::R_SP2:    rd_mux = sp2_r;
      cdio_pkg::R_ARC:    rd_mux = arc_r;
      cdio_pkg::R_STATUS: rd_mux = {12'h000, arc_busy, primed, remote_en_o, is_run};
      cdio_pkg::R_TRIP:   rd_mux = {4'h0, trip_r};
      cdio_pkg::R_ALARM:  rd_mux = {7'h00, alarm_r};
      cdio_pkg::R_INPUTS: rd_mux = io.pins_s;
      cdio_pkg::R_CAP:    rd_mux = {speed_cmd_o, slide_cmd_o};
      default:            rd_mux = '0;
    endcase
  end

  // Read data stand for one cycle only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : '0;
    end
  end
endmodule : cdio_top
